// *** rtl/csw_cfg.svh ***
// Constants of the core sleep, wake and reset control block
`ifndef CSW_CFG_SVH
`define CSW_CFG_SVH
`define CSW_CLK_MHZ 100
`define CSW_ADDR_W 4
`define CSW_DATA_W 32
`define CSW_OFF_CTRL 4'h0
`define CSW_OFF_STAT 4'h4
`define CSW_CTRL_W 4
`define CSW_CTRL_CRST 4
`define CSW_CTRL_PAD 28'h0000000
`define CSW_STAT_PAD 24'h000000
`define CSW_PRIO_W 2
`define CSW_CNT_W 8
`define CSW_WAKE_NS 30
`define CSW_WAKE_CYC ((`CSW_WAKE_NS * `CSW_CLK_MHZ + 999) / 1000)
`define CSW_CRST_NS 80
`define CSW_CRST_CYC ((`CSW_CRST_NS * `CSW_CLK_MHZ + 999) / 1000)
`define CSW_CLK_ALL_ON 3'h7
`define CSW_RST_ALL_ON 3'h7
`define CSW_WORD_BITS 32
`define CSW_PREFETCH_BITS 32
`define CSW_AHEAD_W 2
`define CSW_IO_TAG 4'hD
`define CSW_SYNC_W 34
`endif

// *** rtl/csw_pkg.sv ***
// Types shared by the core sleep, wake and reset control block
`include "csw_cfg.svh"
package csw_pkg;
  typedef enum logic [4:0] {
    CSW_RUN   = 5'h01,
    CSW_SLEEP = 5'h02,
    CSW_DEEP  = 5'h04,
    CSW_WAKE  = 5'h08,
    CSW_CRST  = 5'h10
  } csw_state_type;
  typedef struct packed {
    logic dbg;
    logic sys;
    logic core;
  } csw_clk_type;
  typedef struct packed {
    logic dbg;
    logic core;
    logic power_mgmt_unit;
  } csw_rst_type;
  typedef struct packed {
    logic [`CSW_ADDR_W-1:0] addr;
    logic [`CSW_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } csw_bus_type;
  typedef struct packed {
    logic                   wait_for_event_instr;
    logic                   wait_for_interrupt_instr;
    logic                   send_event_instr;
    logic                   exc_return;
    logic                   exc_pend_new;
    logic                   exc_valid;
    logic [`CSW_PRIO_W-1:0] exc_prio;
    logic                   act_valid;
    logic [`CSW_PRIO_W-1:0] act_prio;
    logic                   dbg_event;
  } csw_core_type;
  typedef struct packed {
    logic deep;
    logic sop;
    logic pmask;
    logic dbgen;
  } csw_ctrl_type;
  typedef struct packed {
    csw_state_type          state;
    logic                   event_flag;
    logic                   wfe_mode;
    csw_ctrl_type           ctrl;
    logic [`CSW_CNT_W-1:0]  cnt;
    csw_clk_type            clk;
    csw_rst_type            rst;
    logic                   tx_event;
    logic                   wfe_done;
    logic                   wfi_done;
    logic [`CSW_DATA_W-1:0] rdata;
  } csw_top_st_type;
endpackage : csw_pkg

// *** rtl/csw_sync.sv ***
// Two-stage synchroniser for asynchronous wake inputs
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_sync #(
  parameter int W = `CSW_SYNC_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } csw_sync_st_type;
  csw_sync_st_type st_q;
  csw_sync_st_type st_d;
  always_comb begin
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign sync_out = st_q.sync;
endmodule : csw_sync

// *** rtl/csw_fetch_gate.sv ***
// Fetch and single-cycle port steering with prefetch limit
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_fetch_gate #(
  parameter logic [3:0] IO_TAG = `CSW_IO_TAG
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        fetch_req,
  input  wire logic [31:0] fetch_addr,
  input  wire logic        instr_used,
  input  wire logic        data_req,
  input  wire logic [31:0] data_addr,
  input  wire logic        dbg_req,
  input  wire logic [31:0] dbg_addr,
  output logic             ahb_fetch_q,
  output logic             fetch_fault_q,
  output logic             io_core_q,
  output logic             io_dbg_q
);
  typedef struct packed {
    logic [`CSW_AHEAD_W-1:0] ahead;
    logic                    ahb_fetch;
    logic                    fault;
    logic                    io_core;
    logic                    io_dbg;
  } csw_fetch_st_type;
  csw_fetch_st_type st_q;
  csw_fetch_st_type st_d;
  logic             grant;
  function automatic logic in_io(input logic [31:0] a);
    in_io = (a[31:28] == IO_TAG);
  endfunction : in_io
  always_comb begin
    st_d = st_q;
    // Words held ahead stay within the prefetch budget
    grant = fetch_req && !in_io(fetch_addr) &&
      ((32'(st_q.ahead) + 32'd1) * `CSW_WORD_BITS <=
       `CSW_PREFETCH_BITS);
    st_d.ahb_fetch = grant;
    st_d.fault = fetch_req && in_io(fetch_addr);
    st_d.io_core = data_req && in_io(data_addr);
    st_d.io_dbg = dbg_req && in_io(dbg_addr);
    if (grant && !instr_used) begin
      st_d.ahead = st_q.ahead + `CSW_AHEAD_W'(1);
    end else if (!grant && instr_used && st_q.ahead != '0) begin
      st_d.ahead = st_q.ahead - `CSW_AHEAD_W'(1);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign ahb_fetch_q   = st_q.ahb_fetch;
  assign fetch_fault_q = st_q.fault;
  assign io_core_q     = st_q.io_core;
  assign io_dbg_q      = st_q.io_dbg;
endmodule : csw_fetch_gate

// *** rtl/csw_ctrl.sv ***
// Sleep, wake, event and reset control for one processor
`timescale 1ns/1ps
`include "csw_cfg.svh"
module csw_ctrl #(
  parameter logic [3:0] IO_TAG = `CSW_IO_TAG
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  csw_pkg::csw_bus_type        bus,
  output logic [`CSW_DATA_W-1:0]      rdata_q,
  input  csw_pkg::csw_core_type       core,
  input  wire logic                   rx_event_async,
  input  wire logic [31:0]            irq_async,
  input  wire logic                   nmi_async,
  input  wire logic                   fetch_req,
  input  wire logic [31:0]            fetch_addr,
  input  wire logic                   instr_used,
  input  wire logic                   data_req,
  input  wire logic [31:0]            data_addr,
  input  wire logic                   dbg_req,
  input  wire logic [31:0]            dbg_addr,
  output logic                        ahb_fetch_q,
  output logic                        fetch_fault_q,
  output logic                        io_core_q,
  output logic                        io_dbg_q,
  output csw_pkg::csw_clk_type        clk_en_q,
  output csw_pkg::csw_rst_type        sub_rst_q,
  output logic                        tx_event_q,
  output logic                        wfe_done_q,
  output logic                        wfi_done_q
);
  localparam int WAKE_LIM = `CSW_WAKE_CYC + 2;
  localparam int CRST_LIM = `CSW_CRST_CYC + 1;

  csw_pkg::csw_top_st_type st_q;
  csw_pkg::csw_top_st_type st_d;
  logic [`CSW_SYNC_W-1:0]  sync_s;
  logic                    rx_ev;
  logic                    nmi_s;
  logic [31:0]             irq_s;
  logic                    dbg_ev;
  logic                    preempt;
  logic                    wfe_evt;
  logic                    wfi_evt;
  logic                    wic_wake;
  logic                    evt_set;
  logic                    crst_req;
  logic                    wfe_fin;
  logic                    wfi_fin;

  // Pins reach the wake logic only through the synchroniser
  csw_sync #(
    .W (`CSW_SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({rx_event_async, nmi_async, irq_async}),
    .sync_out (sync_s)
  );

  csw_fetch_gate #(
    .IO_TAG (IO_TAG)
  ) u_fetch (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .fetch_req     (fetch_req),
    .fetch_addr    (fetch_addr),
    .instr_used    (instr_used),
    .data_req      (data_req),
    .data_addr     (data_addr),
    .dbg_req       (dbg_req),
    .dbg_addr      (dbg_addr),
    .ahb_fetch_q   (ahb_fetch_q),
    .fetch_fault_q (fetch_fault_q),
    .io_core_q     (io_core_q),
    .io_dbg_q      (io_dbg_q)
  );

  assign rx_ev = sync_s[`CSW_SYNC_W-1];
  assign nmi_s = sync_s[`CSW_SYNC_W-2];
  assign irq_s = sync_s[31:0];

  // Lower number is the higher group priority
  function automatic logic preempts(
    input logic                   pend,
    input logic [`CSW_PRIO_W-1:0] pend_prio,
    input logic                   act,
    input logic [`CSW_PRIO_W-1:0] act_prio
  );
    preempts = pend && (!act || pend_prio < act_prio);
  endfunction : preempts

  // Only on or off per domain; no divider, so rates never differ
  function automatic csw_pkg::csw_clk_type clk_for(
    input csw_pkg::csw_state_type s,
    input logic                   dbgen
  );
    csw_pkg::csw_clk_type c;
    c.dbg  = !(s == csw_pkg::CSW_DEEP && !dbgen);
    c.sys  = (s != csw_pkg::CSW_DEEP);
    c.core = (s == csw_pkg::CSW_RUN) ||
             (s == csw_pkg::CSW_CRST);
    clk_for = c;
  endfunction : clk_for

  always_comb begin
    dbg_ev  = st_q.ctrl.dbgen && core.dbg_event;
    preempt = preempts(core.exc_valid, core.exc_prio,
                       core.act_valid, core.act_prio);
    // Masked exceptions cannot be taken, so in CSW_SLEEP only a new pending one with sop set ends an event wait; wfi_evt ignores pmask
    wfe_evt = rx_ev || (st_q.ctrl.sop && core.exc_pend_new) ||
              (preempt && !st_q.ctrl.pmask) || dbg_ev;
    wfi_evt = preempt || dbg_ev;
    wic_wake = (|irq_s) || nmi_s || dbg_ev ||
               (st_q.wfe_mode && rx_ev);
    evt_set = wfe_evt || core.exc_return;
    crst_req = bus.wr && bus.addr == `CSW_OFF_CTRL &&
               bus.wdata[`CSW_CTRL_CRST];
  end

  always_comb begin
    st_d = st_q;
    wfe_fin = 1'b0;
    wfi_fin = 1'b0;
    st_d.tx_event = 1'b0;
    st_d.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        `CSW_OFF_CTRL: begin
          st_d.rdata = {`CSW_CTRL_PAD, st_q.ctrl};
        end
        `CSW_OFF_STAT: begin
          st_d.rdata = {`CSW_STAT_PAD, st_q.state, st_q.clk};
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end
    if (bus.wr && bus.addr == `CSW_OFF_CTRL) begin
      st_d.ctrl = bus.wdata[`CSW_CTRL_W-1:0];
    end
    if (core.send_event_instr && st_q.state == csw_pkg::CSW_RUN) begin
      st_d.tx_event = 1'b1;
    end
    if (crst_req) begin
      // Debug and control logic keep running through this
      st_d.state = csw_pkg::CSW_CRST;
      st_d.cnt = `CSW_CNT_W'(`CSW_CRST_CYC - 1);
    end else begin
      case (st_q.state)
        csw_pkg::CSW_RUN: begin
          if (core.wait_for_event_instr) begin
            if (st_q.event_flag || wfe_evt) begin
              wfe_fin = 1'b1;
            end else begin
              st_d.wfe_mode = 1'b1;
              st_d.state = st_q.ctrl.deep ? csw_pkg::CSW_DEEP
                                          : csw_pkg::CSW_SLEEP;
            end
          end else if (core.wait_for_interrupt_instr) begin
            // Wake inputs are looked at from the next cycle only
            st_d.wfe_mode = 1'b0;
            st_d.state = st_q.ctrl.deep ? csw_pkg::CSW_DEEP
                                        : csw_pkg::CSW_SLEEP;
          end
        end
        csw_pkg::CSW_SLEEP: begin
          if (st_q.wfe_mode ? wfe_evt : wfi_evt) begin
            st_d.state = csw_pkg::CSW_RUN;
            wfe_fin = st_q.wfe_mode;
            wfi_fin = !st_q.wfe_mode;
          end
        end
        csw_pkg::CSW_DEEP: begin
          if (wic_wake) begin
            st_d.state = csw_pkg::CSW_WAKE;
            st_d.cnt = `CSW_CNT_W'(`CSW_WAKE_CYC - 1);
          end
        end
        csw_pkg::CSW_WAKE: begin
          // System clock settles first; core resumes with completion
          if (st_q.cnt == '0) begin
            st_d.state = csw_pkg::CSW_RUN;
            wfe_fin = st_q.wfe_mode;
            wfi_fin = !st_q.wfe_mode;
          end else begin
            st_d.cnt = st_q.cnt - `CSW_CNT_W'(1);
          end
        end
        csw_pkg::CSW_CRST: begin
          if (st_q.cnt == '0) begin
            st_d.state = csw_pkg::CSW_RUN;
          end else begin
            st_d.cnt = st_q.cnt - `CSW_CNT_W'(1);
          end
        end
        default: begin
          st_d.state = csw_pkg::CSW_RUN;
        end
      endcase
    end
    // Flag is internal state only; no bus read shows it, but a core reset request written over the bus clears it
    if (st_d.state == csw_pkg::CSW_CRST) begin
      st_d.event_flag = 1'b0;
    end else if (wfe_fin && st_q.event_flag) begin
      st_d.event_flag = evt_set;
    end else if (wfe_fin) begin
      st_d.event_flag = 1'b0;
    end else begin
      st_d.event_flag = st_q.event_flag || evt_set;
    end
    st_d.wfe_done = wfe_fin;
    st_d.wfi_done = wfi_fin;
    // Core reset follows the reset state; the others only see rst
    st_d.rst.core = (st_d.state == csw_pkg::CSW_CRST);
    st_d.rst.dbg  = 1'b0;
    st_d.rst.power_mgmt_unit  = 1'b0;
    st_d.clk = clk_for(st_d.state, st_d.ctrl.dbgen);
  end

  // Power-up reset asserts all three subsystem resets at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.state <= csw_pkg::CSW_RUN;
      st_q.clk <= `CSW_CLK_ALL_ON;
      st_q.rst <= `CSW_RST_ALL_ON;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_q    = st_q.rdata;
  assign clk_en_q   = st_q.clk;
  assign sub_rst_q  = st_q.rst;
  assign tx_event_q = st_q.tx_event;
  assign wfe_done_q = st_q.wfe_done;
  assign wfi_done_q = st_q.wfi_done;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_WFE_FLAG_SET: assert property (
    st_q.state == csw_pkg::CSW_RUN && core.wait_for_event_instr && st_q.event_flag &&
    !crst_req |=> wfe_done_q && st_q.state == csw_pkg::CSW_RUN)
    else $error("wait with flag set did not complete at once");

  AST_WFE_SLEEPS: assert property (
    st_q.state == csw_pkg::CSW_RUN && core.wait_for_event_instr && !st_q.event_flag &&
    !wfe_evt && !crst_req |=> !wfe_done_q &&
    (st_q.state == csw_pkg::CSW_SLEEP ||
     st_q.state == csw_pkg::CSW_DEEP))
    else $error("wait with flag clear did not sleep");

  AST_DEEP_SELECT: assert property (
    st_q.state == csw_pkg::CSW_RUN && core.wait_for_interrupt_instr && !core.wait_for_event_instr &&
    !crst_req |=> (st_q.state == csw_pkg::CSW_DEEP) ==
    $past(st_q.ctrl.deep))
    else $error("sleep depth does not follow control bit");

  AST_DEEP_CLOCKS: assert property (
    st_q.state == csw_pkg::CSW_DEEP |-> !clk_en_q.core &&
    !clk_en_q.sys && clk_en_q.dbg == st_q.ctrl.dbgen)
    else $error("deep sleep clocks wrong");

  AST_DEEP_WAKE: assert property (
    st_q.state == csw_pkg::CSW_DEEP && wic_wake && !crst_req |->
    ##[1:WAKE_LIM] (clk_en_q.core && (wfe_done_q || wfi_done_q)))
    else $error("deep sleep wake too slow");

  AST_CLK_BEFORE_DONE: assert property (
    wfe_done_q || wfi_done_q |-> clk_en_q.core && clk_en_q.sys)
    else $error("completion seen with core clock stopped");

  AST_SEV_PULSE: assert property (
    st_q.state == csw_pkg::CSW_RUN && core.send_event_instr |=> tx_event_q ##1
    !tx_event_q || $past(core.send_event_instr))
    else $error("send event pulse missing");

  AST_FLAG_SET: assert property (
    st_q.state == csw_pkg::CSW_RUN && !core.wait_for_event_instr && core.exc_return &&
    !crst_req |=> st_q.event_flag)
    else $error("exception return did not set flag");

  AST_FLAG_CORE_RST: assert property (
    crst_req |=> !st_q.event_flag [*2])
    else $error("core reset left event flag set");

  AST_WFI_AFTER_ISSUE: assert property (
    st_q.state == csw_pkg::CSW_RUN && core.wait_for_interrupt_instr && !core.wait_for_event_instr &&
    !crst_req |=> !wfi_done_q)
    else $error("interrupt wait ended before it was issued");

  AST_WFI_LOW_PRIO: assert property (
    st_q.state == csw_pkg::CSW_SLEEP && !st_q.wfe_mode &&
    core.exc_valid && core.act_valid && core.exc_prio >= core.act_prio &&
    !dbg_ev && !crst_req |=> !wfi_done_q)
    else $error("low priority exception ended interrupt wait");

  AST_CORE_RST_ONLY: assert property (
    crst_req |=> sub_rst_q.core && !sub_rst_q.dbg && !sub_rst_q.power_mgmt_unit
    ##[1:CRST_LIM] !sub_rst_q.core)
    else $error("core reset request touched other resets");

  AST_RST_TOGETHER: assert property (
    $fell(sub_rst_q.dbg) |-> $fell(sub_rst_q.power_mgmt_unit) &&
    $fell(sub_rst_q.core))
    else $error("power-up resets not released together");

  COV_WFE_SLEEP_WAKE: cover property (
    st_q.state == csw_pkg::CSW_SLEEP && st_q.wfe_mode ##1 wfe_done_q);
  COV_DEEP_WAKE: cover property (
    st_q.state == csw_pkg::CSW_WAKE ##1 st_q.state == csw_pkg::CSW_RUN);
  COV_CORE_RST: cover property (
    st_q.state == csw_pkg::CSW_CRST ##1 st_q.state == csw_pkg::CSW_RUN);
  COV_WFI_WAKE: cover property (
    st_q.state == csw_pkg::CSW_SLEEP && !st_q.wfe_mode ##1 wfi_done_q);
endmodule : csw_ctrl

// *** bench/csw_peer_model.sv ***
// Peer processor model: sends events and counts events received
`timescale 1ns/1ps
module csw_peer_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       send,
  input  wire logic       tx_event_q,
  output logic            rx_event_async,
  output logic [7:0]      seen_cnt
);
  logic [1:0] hold_q;
  // Two cycles wide so the far synchroniser cannot miss the event
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_q   <= 2'h0;
      seen_cnt <= 8'h00;
    end else begin
      hold_q   <= send ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0};
      seen_cnt <= seen_cnt + {7'h00, tx_event_q};
    end
  end
  assign rx_event_async = hold_q != 2'h0;
endmodule : csw_peer_model

// *** bench/test_csw_ctrl.sv ***
// Self-checking bench for the core sleep, wake and reset control
`timescale 1ns/1ps
`include "csw_cfg.svh"
module test_csw_ctrl;
  logic                  ref_clk, rst, rx_event_async, nmi_async;
  logic                  fetch_req, instr_used, data_req, dbg_req, send;
  logic                  ahb_fetch_q, fetch_fault_q, io_core_q, io_dbg_q;
  logic                  tx_event_q, wfe_done_q, wfi_done_q;
  logic [31:0]           rdata_q, irq_async, fetch_addr, data_addr;
  logic [31:0]           dbg_addr, w, seed;
  logic [7:0]            seen_cnt;
  csw_pkg::csw_bus_type  bus;
  csw_pkg::csw_core_type core;
  csw_pkg::csw_clk_type  clk_en_q;
  csw_pkg::csw_rst_type  sub_rst_q;
  int                    n_mismatch, comparisons, n, k;

  csw_ctrl uut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata_q(rdata_q),
    .core(core), .rx_event_async(rx_event_async), .irq_async(irq_async),
    .nmi_async(nmi_async), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .instr_used(instr_used), .data_req(data_req), .data_addr(data_addr),
    .dbg_req(dbg_req), .dbg_addr(dbg_addr), .ahb_fetch_q(ahb_fetch_q),
    .fetch_fault_q(fetch_fault_q), .io_core_q(io_core_q),
    .io_dbg_q(io_dbg_q), .clk_en_q(clk_en_q), .sub_rst_q(sub_rst_q),
    .tx_event_q(tx_event_q), .wfe_done_q(wfe_done_q),
    .wfi_done_q(wfi_done_q));

  csw_peer_model peer (.ref_clk(ref_clk), .rst(rst), .send(send),
    .tx_event_q(tx_event_q), .rx_event_async(rx_event_async),
    .seen_cnt(seen_cnt));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] stat_exp(input logic [4:0] st,
                                           input logic [2:0] ck);
    return {24'h000000, st, ck};
  endfunction : stat_exp

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results;
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 check(rdata_q, exp);
  endtask : rd_chk

  // 0 wfe, 1 wfi, 2 sev, 3 exception return, 4 new pending, 5 debug
  task automatic pulse(input int p);
    @(posedge ref_clk);
    core.wait_for_event_instr          <= p == 0;
    core.wait_for_interrupt_instr          <= p == 1;
    core.send_event_instr          <= p == 2;
    core.exc_return   <= p == 3;
    core.exc_pend_new <= p == 4;
    core.dbg_event    <= p == 5;
    @(posedge ref_clk);
    core.dbg_event    <= 1'b0;
    core.wait_for_event_instr          <= 1'b0;
    core.wait_for_interrupt_instr          <= 1'b0;
    core.send_event_instr          <= 1'b0;
    core.exc_return   <= 1'b0;
    core.exc_pend_new <= 1'b0;
  endtask : pulse

  task automatic wait_done(input logic sel_wfi, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge ref_clk);
      #1;
      if ((sel_wfi ? wfi_done_q : wfe_done_q) === 1'b1) break;
    end
    check({31'h0, i < lim}, 32'h1);
    if (i >= lim) results();
  endtask : wait_done

  task automatic fetch_chk(input logic [31:0] a, input logic [1:0] exp);
    @(posedge ref_clk);
    fetch_req  <= 1'b1;
    fetch_addr <= a;
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    #1 check({ahb_fetch_q, fetch_fault_q}, exp);
  endtask : fetch_chk

  task automatic peer_send;
    @(posedge ref_clk);
    send <= 1'b1;
    @(posedge ref_clk);
    send <= 1'b0;
  endtask : peer_send

  initial begin
    rst = 1'b1; bus = '0; core = '0; irq_async = '0; nmi_async = 1'b0;
    fetch_req = 1'b0; instr_used = 1'b0; data_req = 1'b0; dbg_req = 1'b0;
    fetch_addr = '0; data_addr = '0; dbg_addr = '0; send = 1'b0;
    n_mismatch = 0; comparisons = 0;
    seed = $urandom(27);
    repeat (4) @(posedge ref_clk);
    #1 check(sub_rst_q, 3'h7);
    check(clk_en_q, 3'h7);
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 check(sub_rst_q, 3'h0);
    rd_chk(4'h4, stat_exp(5'h01, 3'h7));
    w = $urandom & 32'h0000000F;
    wr(4'h0, w);
    wr(4'h8, 32'h0000000F);
    rd_chk(4'h0, w);
    rd_chk(4'h8, 32'h0);
    wr(4'h0, 32'h00000004);
    fetch_chk({4'h1, 28'($urandom)}, 2'h2);
    fetch_chk({4'h2, 28'($urandom)}, 2'h0);
    @(posedge ref_clk);
    instr_used <= 1'b1;
    @(posedge ref_clk);
    instr_used <= 1'b0;
    fetch_chk({4'h3, 28'($urandom)}, 2'h2);
    fetch_chk({`CSW_IO_TAG, 28'($urandom)}, 2'h1);
    for (k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      data_req  <= 1'b1;
      dbg_req   <= 1'b1;
      data_addr <= {(k == 0) ? `CSW_IO_TAG : 4'h2, 28'($urandom)};
      dbg_addr  <= {(k == 1) ? `CSW_IO_TAG : 4'h2, 28'($urandom)};
      @(posedge ref_clk);
      data_req <= 1'b0;
      dbg_req  <= 1'b0;
      #1 check({io_core_q, io_dbg_q}, {k == 0, k == 1});
    end
    pulse(3);
    pulse(0);
    #1 check(wfe_done_q, 1'b1);
    pulse(0);
    #1 check(wfe_done_q, 1'b0);
    rd_chk(4'h4, stat_exp(5'h02, 3'h6));
    pulse(4);
    #1 check(wfe_done_q, 1'b1);
    pulse(0);
    peer_send();
    wait_done(1'b0, 12);
    @(posedge ref_clk);
    core.act_valid <= 1'b1;
    core.act_prio  <= 2'h1;
    core.exc_valid <= 1'b1;
    core.exc_prio  <= 2'h1;
    pulse(1);
    repeat (6) begin
      @(posedge ref_clk);
      #1 check(wfi_done_q, 1'b0);
    end
    @(posedge ref_clk);
    core.exc_prio <= 2'h0;
    wait_done(1'b1, 8);
    @(posedge ref_clk);
    core.exc_valid <= 1'b0;
    core.act_valid <= 1'b0;
    pulse(2);
    #1 check(tx_event_q, 1'b1);
    @(posedge ref_clk);
    #1 check({tx_event_q, seen_cnt}, 9'h001);
    wr(4'h0, 32'h00000008);
    for (k = 0; k < 2; k++) begin
      pulse(1);
      rd_chk(4'h4, stat_exp(5'h04, 3'h0));
      @(posedge ref_clk);
      if (k == 0) irq_async[$urandom_range(31, 0)] <= 1'b1;
      else nmi_async <= 1'b1;
      wait_done(1'b1, 20);
      check(clk_en_q, 3'h7);
      @(posedge ref_clk);
      irq_async <= '0;
      nmi_async <= 1'b0;
    end
    // A core reset request must leave debug and power control running
    wr(4'h0, 32'h00000010);
    n = 0;
    repeat (14) begin
      #1 if (sub_rst_q === 3'h2) n++;
      @(posedge ref_clk);
    end
    check(n, `CSW_CRST_CYC);
    #1 check(sub_rst_q, 3'h0);
    pulse(0);
    #1 check(wfe_done_q, 1'b0);
    peer_send();
    wait_done(1'b0, 12);
    // Debug enabled and exceptions masked for the last wait
    wr(4'h0, 32'h00000003);
    pulse(0);
    #1 check(wfe_done_q, 1'b1);
    pulse(0);
    #1 check(wfe_done_q, 1'b0);
    @(posedge ref_clk);
    core.exc_valid <= 1'b1;
    core.exc_prio  <= 2'h0;
    repeat (4) begin
      @(posedge ref_clk);
      #1 check(wfe_done_q, 1'b0);
    end
    pulse(5);
    #1 check(wfe_done_q, 1'b1);
    results();
  end
endmodule : test_csw_ctrl
